/* File: src/tcw_timer.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "tcw_defines.svh"

module tcw_channel #(
  parameter int CNT_W = 16
) (
  input wire logic refClk,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic srRead,
  input wire logic [5:0] regOff,
  input wire logic [31:0] wdata,
  input wire logic syncTrig,
  input wire logic [4:0] intTick,
  input wire logic [2:0] xcLevel,
  input wire logic ioBIn,
  output logic [31:0] rdata,
  output logic regHit,
  output logic ioAOut_q,
  output logic ioAOe_q,
  output logic ioBOut_q,
  output logic ioBOe_q
);
  // ****************************************************************
  // Registers and decode
  // ****************************************************************
  logic [31:0] cmr_q;
  logic [CNT_W-1:0] cv_q, ra_q, rb_q, rc_q, cvTop;
  logic [`TCW_SR_W-1:0] sr_q, imr_q, srSet;
  logic clkEn_q, clkRun_q, down_q, pend_q, cvUpd_q, xcPrev_q, evPrev_q;
  logic wave, bIsEvent, wrCcr, swTrig, swEvent, extEvent, extTrig, anyTrig;
  logic tick, srcLvl, burstOk, evSrc, step, matchA, matchB, matchC, ovf;
  logic [1:0] actA, actB;
  tcw_pkg::tcw_shape_e shape;
  logic enNow;

  assign wave = cmr_q[`TCW_CMR_WAVE];
  assign shape = tcw_pkg::tcw_shape_e'(cmr_q[`TCW_CMR_COUNT_SHAPE_SELECT]);
  assign bIsEvent = wave && (cmr_q[`TCW_CMR_EXT_EVENT_SOURCE] == `TCW_EXT_EVENT_SOURCE_IOB);
  assign wrCcr = wrEn && (regOff == `TCW_OFF_CCR);
  assign swTrig = wrCcr && wdata[`TCW_CCR_SOFT_TRIGGER_CMD];
  assign swEvent = swTrig || syncTrig;
  // A trigger written together with the enable command starts the clock at once
  assign enNow = clkEn_q || (wrCcr && wdata[`TCW_CCR_CLKEN] && !wdata[`TCW_CCR_CLKDIS]);

  // Counter clock source: prescaled internal tick or an external clock edge
  always_comb begin
    case (cmr_q[`TCW_CMR_TCCLKS])
      `TCW_CLKS_XC0: srcLvl = xcLevel[0];
      `TCW_CLKS_XC1: srcLvl = xcLevel[1];
      `TCW_CLKS_XC2: srcLvl = xcLevel[2];
      default: srcLvl = 1'b0;
    endcase
    case (cmr_q[`TCW_CMR_BURST])
      `TCW_BURST_XC0: burstOk = xcLevel[0];
      `TCW_BURST_XC1: burstOk = xcLevel[1];
      `TCW_BURST_XC2: burstOk = xcLevel[2];
      default: burstOk = 1'b1;
    endcase
    if (cmr_q[`TCW_CMR_TCCLKS] == `TCW_CLKS_INT5) begin
      tick = intTick[4];
    end else if (cmr_q[`TCW_CMR_TCCLKS] >= `TCW_CLKS_XC0) begin
      // Edge of the synchronised level; invert picks the falling edge
      tick = cmr_q[`TCW_CMR_CLKI] ? (xcPrev_q && !srcLvl) : (!xcPrev_q && srcLvl);
    end else begin
      tick = intTick[cmr_q[`TCW_CMR_INTSEL]];
    end
    tick = tick && burstOk;
  end

  // External event selection and edge detection
  always_comb begin
    case (cmr_q[`TCW_CMR_EXT_EVENT_SOURCE])
      2'h1: evSrc = xcLevel[0];
      2'h2: evSrc = xcLevel[1];
      2'h3: evSrc = xcLevel[2];
      default: evSrc = ioBIn;
    endcase
    extEvent = wave
      && ((cmr_q[`TCW_CMR_EEV_RISE] && !evPrev_q && evSrc)
      || (cmr_q[`TCW_CMR_EEV_FALL] && evPrev_q && !evSrc));
  end
  assign extTrig = extEvent && cmr_q[`TCW_CMR_EXT_EVENT_TRIGGER_ENABLE];
  assign anyTrig = swEvent || extTrig;

  // Compare events are judged on the value just counted into
  assign matchA = wave && cvUpd_q && (cv_q == ra_q);
  assign matchB = wave && cvUpd_q && (cv_q == rb_q) && !bIsEvent;
  assign matchC = wave && cvUpd_q && (cv_q == rc_q);
  assign step = tick && clkEn_q && clkRun_q;
  assign cvTop = (shape == tcw_pkg::TCW_UPDN_RC) ? rc_q : {CNT_W{1'b1}};
  assign ovf = step && !pend_q && (cv_q == {CNT_W{1'b1}}) && (shape == tcw_pkg::TCW_UP_MAX);

  // ****************************************************************
  // Register writes
  // ****************************************************************
  always_ff @(posedge refClk) begin
    if (reset) begin
      cmr_q <= `TCW_ZERO32;
      ra_q <= '0;
      rb_q <= '0;
      rc_q <= '0;
      imr_q <= '0;
    end else if (wrEn) begin
      if (regOff == `TCW_OFF_CMR) begin
        cmr_q <= wdata;
      end else if (regOff == `TCW_OFF_RA && wave) begin
        ra_q <= wdata[CNT_W-1:0];
      end else if (regOff == `TCW_OFF_RB && wave) begin
        rb_q <= wdata[CNT_W-1:0];
      end else if (regOff == `TCW_OFF_RC) begin
        rc_q <= wdata[CNT_W-1:0];
      end else if (regOff == `TCW_OFF_IER) begin
        imr_q <= imr_q | wdata[`TCW_SR_W-1:0];
      end else if (regOff == `TCW_OFF_IDR) begin
        imr_q <= imr_q & ~wdata[`TCW_SR_W-1:0];
      end
    end
  end

  // Clock enable and run; a disabled clock ignores start and stop
  always_ff @(posedge refClk) begin
    if (reset) begin
      clkEn_q <= 1'b0;
      clkRun_q <= 1'b0;
    end else begin
      if (wrCcr && wdata[`TCW_CCR_CLKDIS]) begin
        clkEn_q <= 1'b0;
      end else if (matchC && cmr_q[`TCW_CMR_MATCH_C_GATE_OFF]) begin
        clkEn_q <= 1'b0;
      end else if (wrCcr && wdata[`TCW_CCR_CLKEN]) begin
        clkEn_q <= 1'b1;
      end
      if (enNow && anyTrig) begin
        clkRun_q <= 1'b1; // start wins over a coinciding stop
      end else if (clkEn_q && matchC && cmr_q[`TCW_CMR_MATCH_C_HALT]) begin
        clkRun_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Counter; a trigger is applied at the next counting edge
  // ****************************************************************
  always_ff @(posedge refClk) begin
    if (reset) begin
      cv_q <= '0;
      down_q <= 1'b0;
      pend_q <= 1'b0;
      cvUpd_q <= 1'b0;
      xcPrev_q <= 1'b0;
      evPrev_q <= 1'b0;
    end else begin
      xcPrev_q <= srcLvl;
      evPrev_q <= evSrc;
      cvUpd_q <= step;
      if (anyTrig) begin
        pend_q <= 1'b1; // A new trigger beats the consumption of the old one
      end else if (step) begin
        pend_q <= 1'b0;
      end
      if (step) begin
        if (pend_q && (shape == tcw_pkg::TCW_UP_MAX || shape == tcw_pkg::TCW_UP_RC)) begin
          cv_q <= '0;
          down_q <= 1'b0;
        end else if (pend_q) begin
          down_q <= !down_q;
        end else begin
          case (shape)
            tcw_pkg::TCW_UP_MAX: begin
              cv_q <= cv_q + 1'b1; // compare C never resets
            end
            tcw_pkg::TCW_UP_RC: begin
              cv_q <= (cv_q == rc_q) ? '0 : cv_q + 1'b1;
            end
            default: begin
              if (cvTop == '0) begin
                cv_q <= '0; // Degenerate limit holds at zero
              end else if (!down_q && cv_q >= cvTop) begin
                down_q <= 1'b1;
                cv_q <= cv_q - 1'b1;
              end else if (down_q && cv_q == '0) begin
                down_q <= 1'b0;
                cv_q <= cv_q + 1'b1;
              end else begin
                cv_q <= down_q ? cv_q - 1'b1 : cv_q + 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  // ****************************************************************
  // Status flags: set by events, cleared by a read, set wins
  // ****************************************************************
  always_comb begin
    srSet = '0;
    srSet[`TCW_SR_COVFS] = ovf;
    srSet[`TCW_SR_CPAS] = matchA;
    srSet[`TCW_SR_CPBS] = matchB;
    srSet[`TCW_SR_CPCS] = matchC;
    srSet[`TCW_SR_ETRGS] = extEvent;
  end

  always_ff @(posedge refClk) begin
    if (reset) begin
      sr_q <= '0;
    end else begin
      sr_q <= (srRead ? '0 : sr_q) | srSet;
    end
  end

  // ****************************************************************
  // Output controller
  // ****************************************************************
  // Later checks override earlier: software > external > compare C > own compare
  always_comb begin
    actA = tcw_pkg::TCW_ACT_NONE;
    actB = tcw_pkg::TCW_ACT_NONE;
    if (matchA) actA = cmr_q[`TCW_CMR_ACPA];
    if (matchC && cmr_q[`TCW_CMR_ACPC] != 2'h0) actA = cmr_q[`TCW_CMR_ACPC];
    if (extEvent && cmr_q[`TCW_CMR_AEEVT] != 2'h0) actA = cmr_q[`TCW_CMR_AEEVT];
    if (swEvent && cmr_q[`TCW_CMR_ASWTRG] != 2'h0) actA = cmr_q[`TCW_CMR_ASWTRG];
    if (matchB) actB = cmr_q[`TCW_CMR_BCPB];
    if (matchC && cmr_q[`TCW_CMR_BCPC] != 2'h0) actB = cmr_q[`TCW_CMR_BCPC];
    if (extEvent && cmr_q[`TCW_CMR_BEEVT] != 2'h0) actB = cmr_q[`TCW_CMR_BEEVT];
    if (swEvent && cmr_q[`TCW_CMR_BSWTRG] != 2'h0) actB = cmr_q[`TCW_CMR_BSWTRG];
    if (!wave || bIsEvent) actB = tcw_pkg::TCW_ACT_NONE;
    if (!wave) actA = tcw_pkg::TCW_ACT_NONE;
  end

  function automatic logic applyAct(input logic cur, input logic [1:0] act);
    case (tcw_pkg::tcw_act_e'(act))
      tcw_pkg::TCW_ACT_SET: applyAct = 1'b1;
      tcw_pkg::TCW_ACT_CLEAR: applyAct = 1'b0;
      tcw_pkg::TCW_ACT_TOGGLE: applyAct = !cur;
      default: applyAct = cur;
    endcase
  endfunction

  always_ff @(posedge refClk) begin
    if (reset) begin
      ioAOut_q <= 1'b0;
      ioBOut_q <= 1'b0;
      ioAOe_q <= 1'b0;
      ioBOe_q <= 1'b0;
    end else begin
      ioAOut_q <= applyAct(ioAOut_q, actA);
      ioBOut_q <= applyAct(ioBOut_q, actB);
      ioAOe_q <= wave;
      ioBOe_q <= wave && !bIsEvent;
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always_comb begin
    rdata = `TCW_ZERO32;
    regHit = 1'b1;
    if (regOff == `TCW_OFF_CCR || regOff == `TCW_OFF_IER || regOff == `TCW_OFF_IDR) begin
      rdata = `TCW_ZERO32; // Write-only registers read as zero
    end else if (regOff == `TCW_OFF_CMR) begin
      rdata = cmr_q;
    end else if (regOff == `TCW_OFF_CV) begin
      rdata = 32'(cv_q);
    end else if (regOff == `TCW_OFF_RA) begin
      rdata = 32'(ra_q);
    end else if (regOff == `TCW_OFF_RB) begin
      rdata = 32'(rb_q);
    end else if (regOff == `TCW_OFF_RC) begin
      rdata = 32'(rc_q);
    end else if (regOff == `TCW_OFF_SR) begin
      rdata = 32'(sr_q);
      rdata[`TCW_SR_CLKSTA] = clkEn_q;
    end else if (regOff == `TCW_OFF_IMR) begin
      rdata = 32'(imr_q);
    end else begin
      regHit = 1'b0;
    end
  end
endmodule // tcw_channel

module tcw_timer #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] clockPinIn,
  input wire logic [2:0] ioLineAIn,
  output logic [2:0] ioLineAOut,
  output logic [2:0] ioLineAOe,
  input wire logic [2:0] ioLineBIn,
  output logic [2:0] ioLineBOut,
  output logic [2:0] ioLineBOe
);
  // ****************************************************************
  // Bus slave: one wait state, data and answer registered
  // ****************************************************************
  logic pready_q, pslverr_q;
  logic [31:0] prdata_q, rdMux;
  logic [`TCW_BMR_W-1:0] bmr_q;
  logic [`TCW_PRESC_W-1:0] presc_q;
  logic [4:0] intTick_q;
  logic [8:0] pinS1_q, pinS2_q, pinS3_q, pinF_q;
  logic [2:0] xcLevel, chainA, chWr, chRd, regHit;
  logic [31:0] chData [3];
  logic acc, blk, syncTrig, hit, capt;
  logic [1:0] chIdx;

  assign acc = psel && penable && pready_q; // Effect edge of the transfer
  assign capt = psel && penable && !pready_q; // Edge at which read data is captured
  assign chIdx = paddr[7:6];
  assign blk = (chIdx == `TCW_BLK_SEL);
  assign syncTrig = acc && pwrite && (paddr == `TCW_OFF_BCR) && pwdata[`TCW_BCR_SYNC];

  // Per-channel strobes and the read mux
  always_comb begin
    chWr = '0;
    chRd = '0;
    rdMux = `TCW_ZERO32;
    hit = 1'b0;
    if (!blk) begin
      chWr[chIdx] = acc && pwrite;
      chRd[chIdx] = capt && !pwrite && (paddr[5:0] == `TCW_OFF_SR); // Later sets survive
      rdMux = chData[chIdx];
      hit = regHit[chIdx];
    end else if (paddr == `TCW_OFF_BCR) begin
      hit = 1'b1;
    end else if (paddr == `TCW_OFF_BMR) begin
      rdMux = 32'(bmr_q);
      hit = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= `TCW_ZERO32;
    end else begin
      pready_q <= psel && penable && !pready_q;
      pslverr_q <= psel && penable && !pready_q && !hit;
      prdata_q <= (psel && penable && !pready_q && !pwrite) ? rdMux : `TCW_ZERO32;
    end
  end

  // Block mode register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bmr_q <= '0;
    end else if (acc && pwrite && paddr == `TCW_OFF_BMR) begin
      bmr_q <= pwdata[`TCW_BMR_W-1:0];
    end
  end

  // ****************************************************************
  // Pin synchronisers and internal prescaler
  // ****************************************************************
  // A change counts only when stages two and three agree, rejecting glitches
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinS1_q <= '0;
      pinS2_q <= '0;
      pinS3_q <= '0;
      pinF_q <= '0;
    end else begin
      pinS1_q <= {ioLineBIn, ioLineAIn, clockPinIn};
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      pinF_q <= (pinS2_q & pinS3_q) | (pinF_q & (pinS2_q ^ pinS3_q));
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      presc_q <= '0;
      intTick_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
      intTick_q[0] <= (presc_q & `TCW_DIV1_MASK) == `TCW_DIV1_MASK;
      intTick_q[1] <= (presc_q & `TCW_DIV2_MASK) == `TCW_DIV2_MASK;
      intTick_q[2] <= (presc_q & `TCW_DIV3_MASK) == `TCW_DIV3_MASK;
      intTick_q[3] <= (presc_q & `TCW_DIV4_MASK) == `TCW_DIV4_MASK;
      intTick_q[4] <= (presc_q & `TCW_DIV5_MASK) == `TCW_DIV5_MASK;
    end
  end

  // ****************************************************************
  // External clock routing; chaining uses the driven line A level, or the line A pin level while line A is not driven
  // ****************************************************************
  assign chainA = (ioLineAOe & ioLineAOut) | (~ioLineAOe & pinF_q[5:3]);

  function automatic logic route(input logic [1:0] sel, input logic pin,
                                 input logic lo, input logic hi);
    if (sel == `TCW_ROUTE_PIN) route = pin;
    else if (sel == `TCW_ROUTE_NONE) route = 1'b0;
    else if (sel == `TCW_ROUTE_IOA_LO) route = lo;
    else route = hi;
  endfunction

  assign xcLevel[0] = route(bmr_q[`TCW_BMR_XC0S], pinF_q[0], chainA[1], chainA[2]);
  assign xcLevel[1] = route(bmr_q[`TCW_BMR_XC1S], pinF_q[1], chainA[0], chainA[2]);
  assign xcLevel[2] = route(bmr_q[`TCW_BMR_XC2S], pinF_q[2], chainA[0], chainA[1]);

  genvar gi;
  generate
    for (gi = 0; gi < `TCW_NUM_CH; gi++) begin : gCh
      tcw_channel #(.CNT_W(CNT_W)) uCh (
        .refClk(ref_clk),
        .reset(reset),
        .wrEn(chWr[gi]),
        .srRead(chRd[gi]),
        .regOff(paddr[5:0]),
        .wdata(pwdata),
        .syncTrig(syncTrig),
        .intTick(intTick_q),
        .xcLevel(xcLevel),
        .ioBIn(pinF_q[6 + gi]),
        .rdata(chData[gi]),
        .regHit(regHit[gi]),
        .ioAOut_q(ioLineAOut[gi]),
        .ioAOe_q(ioLineAOe[gi]),
        .ioBOut_q(ioLineBOut[gi]),
        .ioBOe_q(ioLineBOe[gi])
      );
    end
  endgenerate

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
endmodule // tcw_timer

/* File: src/tcw_defines.svh */
`ifndef TCW_DEFINES_SVH
`define TCW_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define TCW_CH_STRIDE 8'h40
`define TCW_NUM_CH 3
`define TCW_OFF_CCR 6'h00
`define TCW_OFF_CMR 6'h04
`define TCW_OFF_CV 6'h10
`define TCW_OFF_RA 6'h14
`define TCW_OFF_RB 6'h18
`define TCW_OFF_RC 6'h1C
`define TCW_OFF_SR 6'h20
`define TCW_OFF_IER 6'h24
`define TCW_OFF_IDR 6'h28
`define TCW_OFF_IMR 6'h2C
`define TCW_OFF_BCR 8'hC0
`define TCW_OFF_BMR 8'hC4
`define TCW_BLK_SEL 2'h3

// ****************************************************************
// Field positions
// ****************************************************************
`define TCW_CCR_CLKEN 0
`define TCW_CCR_CLKDIS 1
`define TCW_CCR_SOFT_TRIGGER_CMD 2
`define TCW_BCR_SYNC 0
`define TCW_CMR_TCCLKS 2:0
`define TCW_CMR_INTSEL 1:0
`define TCW_CMR_CLKI 3
`define TCW_CMR_BURST 5:4
`define TCW_CMR_MATCH_C_HALT 6
`define TCW_CMR_MATCH_C_GATE_OFF 7
`define TCW_CMR_EXT_EVENT_EDGE 9:8
`define TCW_CMR_EEV_RISE 8
`define TCW_CMR_EEV_FALL 9
`define TCW_CMR_EXT_EVENT_SOURCE 11:10
`define TCW_CMR_EXT_EVENT_TRIGGER_ENABLE 12
`define TCW_CMR_COUNT_SHAPE_SELECT 14:13
`define TCW_CMR_WAVE 15
`define TCW_CMR_ACPA 17:16
`define TCW_CMR_ACPC 19:18
`define TCW_CMR_AEEVT 21:20
`define TCW_CMR_ASWTRG 23:22
`define TCW_CMR_BCPB 25:24
`define TCW_CMR_BCPC 27:26
`define TCW_CMR_BEEVT 29:28
`define TCW_CMR_BSWTRG 31:30
`define TCW_BMR_XC0S 1:0
`define TCW_BMR_XC1S 3:2
`define TCW_BMR_XC2S 5:4
`define TCW_BMR_W 6
`define TCW_SR_COVFS 0
`define TCW_SR_CPAS 2
`define TCW_SR_CPBS 3
`define TCW_SR_CPCS 4
`define TCW_SR_ETRGS 7
`define TCW_SR_CLKSTA 16
`define TCW_SR_W 8

// ****************************************************************
// Codes, reset values and prescaler masks
// ****************************************************************
`define TCW_EXT_EVENT_SOURCE_IOB 2'h0
`define TCW_EDGE_RISE 1
`define TCW_EDGE_FALL 2
`define TCW_CLKS_INT5 3'h4
`define TCW_CLKS_XC0 3'h5
`define TCW_CLKS_XC1 3'h6
`define TCW_CLKS_XC2 3'h7
`define TCW_BURST_XC0 2'h1
`define TCW_BURST_XC1 2'h2
`define TCW_BURST_XC2 2'h3
`define TCW_ROUTE_PIN 2'h0
`define TCW_ROUTE_NONE 2'h1
`define TCW_ROUTE_IOA_LO 2'h2
`define TCW_ZERO32 32'h00000000
`define TCW_PRESC_W 9
`define TCW_DIV1_MASK 9'h001
`define TCW_DIV2_MASK 9'h007
`define TCW_DIV3_MASK 9'h01F
`define TCW_DIV4_MASK 9'h07F
`define TCW_DIV5_MASK 9'h1FF

`endif

/* File: src/tcw_pkg.sv */
package tcw_pkg;
  // Count shapes, encoded as the hardware field values
  typedef enum logic [1:0] {
    TCW_UP_MAX = 2'h0,
    TCW_UPDN_MAX = 2'h1,
    TCW_UP_RC = 2'h2,
    TCW_UPDN_RC = 2'h3
  } tcw_shape_e;
  // Output controller actions
  typedef enum logic [1:0] {
    TCW_ACT_NONE = 2'h0,
    TCW_ACT_SET = 2'h1,
    TCW_ACT_CLEAR = 2'h2,
    TCW_ACT_TOGGLE = 2'h3
  } tcw_act_e;
endpackage

/* File: tb/tcw_checker.sv */
`timescale 1ns/1ps
module tcw_checker #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] ioLineAOe,
  input wire logic [2:0] ioLineBOe
);
  // ******************************
  // Bus answer and line direction
  // ******************************
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  AST_ONE_WAIT: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("answer not after exactly one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  AST_READY_CAUSE: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("pready without an access phase");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h00000000)
    else $error("prdata not zero outside the answer");
  AST_UNMAPPED: assert property (pready && paddr[7:6] != 2'h3 && paddr[5:0] > 6'h2C |-> pslverr)
    else $error("unmapped channel offset accepted");
  AST_LINE_B_NEEDS_A: assert property (|ioLineBOe |-> (ioLineBOe & ~ioLineAOe) == 3'h0)
    else $error("line B driven while line A is not");
  AST_RESET_QUIET: assert property ($past(reset) |-> !pready && ioLineAOe == 3'h0 && ioLineBOe == 3'h0)
    else $error("outputs active at first edge after reset");
endmodule // tcw_checker

bind tcw_timer tcw_checker #(.CNT_W(CNT_W)) tcw_checker_inst (.ref_clk(ref_clk), .reset(reset),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ioLineAOe(ioLineAOe), .ioLineBOe(ioLineBOe));

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [2:0] clockPinIn = 3'h0;
  logic [31:0] prdata, rv, c1, mx;
  logic pready, pslverr, ev, dn;
  logic [2:0] aOut, aOe, bOut, bOe;
  int failures = 0;
  int num_checks = 0;
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  tcw_timer tcw_timer_inst (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clockPinIn(clockPinIn), .ioLineAIn(3'h0), .ioLineAOut(aOut),
    .ioLineAOe(aOe), .ioLineBIn(3'h0), .ioLineBOut(bOut), .ioLineBOe(bOe));
  // ******************************
  // Report, compare and bus tasks
  // ******************************
  task end_sim;
    $display("CHECKS %0d FAILURES %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Request held until the rising edge that samples pready high; data taken there
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        failures++;
        end_sim();
      end
      @(posedge ref_clk);
    end
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk($sformatf("reg %h", a), exp, rv);
  endtask
  // Bounded wait for line A of channel 0
  task waitA(input logic v);
    int n;
    n = 0;
    while (aOut[0] !== v && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    chk("lineA", {31'h0, v}, {31'h0, aOut[0]});
  endtask
  task pulse;
    clockPinIn[0] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    clockPinIn[0] <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  // Hang guard
  initial begin
    repeat (50000) @(posedge ref_clk);
    failures++;
    end_sim();
  end
  // ******************************
  // Scenarios
  // ******************************
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    rdc(8'h04, 32'h0);
    rdc(8'h10, 32'h0);
    rdc(8'h2C, 32'h0);
    rdc(8'hC4, 32'h0);
    rdc(8'h00, 32'h0);
    chk("lineA oe capture", 32'h0, {29'h0, aOe});
    apb(1'b0, 8'h08, 32'h0);
    chk("err 08", 32'h1, {31'h0, ev});
    apb(1'b0, 8'hD8, 32'h0);
    chk("err D8", 32'h1, {31'h0, ev});
    wr(8'h14, 32'h1234);
    rdc(8'h14, 32'h0);
    wr(8'h04, 32'h8000);
    wr(8'h14, 32'h1234);
    rdc(8'h14, 32'h1234);
    chk("lineA oe", 32'h1, {31'h0, aOe[0]});
    chk("lineB oe", 32'h0, {31'h0, bOe[0]});
    wr(8'h04, 32'h8400);
    repeat (2) @(posedge ref_clk);
    chk("lineB oe", 32'h1, {31'h0, bOe[0]});
    wr(8'hC4, 32'h2C);
    rdc(8'hC4, 32'h2C);
    for (int i = 0; i < 3; i++) wr(8'(i * 64 + 28), 32'h10 + i);
    for (int i = 0; i < 3; i++) rdc(8'(i * 64 + 28), 32'h10 + i);
    // Shape 10, line A set on compare A and cleared on compare C
    wr(8'h1C, 32'h3);
    wr(8'h14, 32'h1);
    wr(8'h04, 32'h0009C000);
    wr(8'h00, 32'h5);
    repeat (10) begin
      apb(1'b0, 8'h10, 32'h0);
      chk("cv up to C", 32'h1, {31'h0, rv <= 3});
    end
    waitA(1'b1);
    waitA(1'b0);
    // Shape 11 must turn round at compare C
    wr(8'h04, 32'h0000E000);
    mx = 0;
    dn = 0;
    c1 = 0;
    repeat (16) begin
      apb(1'b0, 8'h10, 32'h0);
      if (rv < c1) dn = 1;
      if (rv > mx) mx = rv;
      c1 = rv;
    end
    chk("updown max", 32'h1, {31'h0, mx <= 3});
    chk("updown falls", 32'h1, {31'h0, dn});
    // Shape 00 runs past compare C; a soft trigger restarts it
    wr(8'h04, 32'h00008000);
    wr(8'h00, 32'h4);
    repeat (100) @(posedge ref_clk);
    apb(1'b0, 8'h10, 32'h0);
    c1 = rv;
    chk("past C", 32'h1, {31'h0, c1 > 3});
    wr(8'h00, 32'h4);
    apb(1'b0, 8'h10, 32'h0);
    chk("restart", 32'h1, {31'h0, rv < c1});
    // Shape 01: a trigger while rising makes it fall
    wr(8'h04, 32'h0000A000);
    repeat (60) @(posedge ref_clk);
    apb(1'b0, 8'h10, 32'h0);
    c1 = rv;
    wr(8'h00, 32'h4);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, 8'h10, 32'h0);
    chk("reverse", 32'h1, {31'h0, rv < c1});
    // Halt on compare C, then the block-wide trigger restarts it
    wr(8'h04, 32'h0000C040);
    wr(8'h00, 32'h4);
    repeat (40) @(posedge ref_clk);
    apb(1'b0, 8'h10, 32'h0);
    chk("halted", 32'h3, rv);
    rdc(8'h10, 32'h3);
    wr(8'h1C, 32'h40);
    wr(8'hC0, 32'h1);
    repeat (20) @(posedge ref_clk);
    apb(1'b0, 8'h10, 32'h0);
    chk("sync restart", 32'h1, {31'h0, rv > 3});
    // Gate-off clears the clock-enabled status
    wr(8'h04, 32'h0000C080);
    wr(8'h00, 32'h4);
    repeat (200) @(posedge ref_clk);
    apb(1'b0, 8'h20, 32'h0);
    chk("clock on", 32'h0, {31'h0, rv[16]});
    // Rising edge on clock pin 0 as event, then edge none
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h0000D500);
    apb(1'b0, 8'h20, 32'h0);
    pulse();
    apb(1'b0, 8'h20, 32'h0);
    chk("event", 32'h1, {31'h0, rv[7]});
    wr(8'h04, 32'h0000D400);
    apb(1'b0, 8'h20, 32'h0);
    pulse();
    apb(1'b0, 8'h20, 32'h0);
    chk("no event", 32'h0, {31'h0, rv[7]});
    end_sim();
  end
endmodule // tb_top
